/* hdl/ups_pkg.sv */
/*
 ups_pkg: constants, register offsets, field positions and types
 for the pin strap capture and serial port block.
 assumes one clock and byte-wide register access.
*/
package ups_pkg;
    // register bus widths
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    // register offsets
    localparam logic [7:0] REG_GOPT = 8'h24; // global_option_cfg_reg
    localparam logic [7:0] REG_GOPT2 = 8'h26; // global_option2_cfg_reg
    localparam logic [7:0] REG_STAT = 8'h28; // modem and buffer status
    localparam logic [7:0] REG_CTRL = 8'h29; // modem control outputs
    localparam logic [7:0] REG_TXA = 8'h2A; // port a transmit data
    localparam logic [7:0] REG_TXB = 8'h2B; // port b transmit data
    localparam logic [7:0] REG_RX = 8'h2C; // port a received data
    // field positions
    localparam int PNP_BIT = 0; // pnp_default_clear_strap
    localparam int ROM_BIT = 1; // boot_rom_enable_strap
    localparam int CLK48_BIT = 6; // clk48_select_bit
    localparam int CFGADR_BIT = 6; // cfg_port_addr_strap
    localparam int CTRL_RTS_A = 0;
    localparam int CTRL_DTR_A = 1;
    localparam int CTRL_RTS_B = 2;
    localparam int CTRL_DTR_B = 3;
    // reset values of plain registers
    localparam logic [7:0] CTRL_RST = 8'h00;
    // configuration port addresses
    localparam logic [7:0] CFG_ADDR_ALT = 8'h4E;
    localparam logic [7:0] CFG_ADDR_DEF = 8'h2E;
    // serial timing: clocks per bit, transmit buffer depth
    localparam int BAUD_DIV = 16;
    localparam int FIFO_DEPTH = 2;
    // bus request from software
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ups_bus_req_type;
    // modem status inputs, all active low
    typedef struct packed {
        logic carrier_n;
        logic ring_n;
        logic set_ready_n;
    } ups_modem_in_type;
    // two-way strap pin: level, enable, weak pull-down
    typedef struct packed {
        logic drive;
        logic oe;
        logic pull_down;
    } ups_pin_type;
    // serial shifter states
    typedef enum logic [1:0] {
        ST_IDLE, ST_START, ST_DATA, ST_STOP
    } ups_state_type;
endpackage : ups_pkg

/* hdl/ups_strap_top.sv */
/*
 ups_strap_top: strap capture at reset, configuration registers,
 modem control pins and two serial ports with two-entry buffers.
 assumes synchronous inputs, plain register port, board pull-ups.
*/
// The address map and the strobed register port were decided locally.
// Behaviour
// - pull strap pins low during reset
// - port a rts level sets address strap
// - address strap high selects port 4Eh
// - port a dtr level sets pnp strap
// - pnp strap high clears default settings
// - port a serial out sets rom strap
// - port b serial out sets 48MHz strap
// - rts low when ready to send
// - dtr low when ready to communicate
// - serial in received, serial out shifted
`timescale 1ns/100ps
module ups_strap_top
    import ups_pkg::*;
#(
    parameter int BAUD = ups_pkg::BAUD_DIV,
    parameter logic [7:0] DEF_ADDR = ups_pkg::CFG_ADDR_DEF
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire ups_pkg::ups_bus_req_type i_bus,
    output logic [7:0] o_rdata,
    input wire logic i_port_a_req_to_send_n,
    input wire logic i_port_a_term_ready_n,
    input wire logic i_port_a_serial_out,
    input wire logic i_port_b_serial_out,
    output ups_pkg::ups_pin_type o_port_a_req_to_send_n,
    output ups_pkg::ups_pin_type o_port_a_term_ready_n,
    output ups_pkg::ups_pin_type o_port_a_serial_out,
    output ups_pkg::ups_pin_type o_port_b_serial_out,
    output logic o_port_b_req_to_send_n,
    output logic o_port_b_term_ready_n,
    input wire logic i_port_a_serial_in,
    input wire ups_pkg::ups_modem_in_type i_modem,
    output logic [7:0] o_cfg_port_addr,
    output logic o_pnp_default_clear_strap,
    output logic o_boot_rom_enable_strap,
    output logic o_clk48_select_bit,
    output logic [1:0] o_tx_ready
);
    import ups_pkg::*;

    // baud counter width
    localparam int CW = $clog2(BAUD);
    localparam logic [CW-1:0] LAST = CW'(BAUD - 1);
    localparam logic [CW-1:0] HALF = CW'(BAUD / 2);

    // end of one bit time
    function automatic logic bit_end(input logic [CW-1:0] c);
        bit_end = (c == LAST);
    endfunction : bit_end

    // configuration, control and read data
    logic [7:0] gopt, next_gopt;
    logic [7:0] gopt2, next_gopt2;
    logic [7:0] ctrl, next_ctrl;
    logic [7:0] rdata, next_rdata;
    logic [7:0] cfg_addr, next_cfg_addr;
    logic [3:0] mdm_n, next_mdm_n; // registered modem pins
    logic pins_on, next_pins_on; // pins handed to serial use
    logic pull_dn, next_pull_dn; // weak pull-down enable
    logic [1:0] txr, next_txr; // buffer not full

    // configuration registers and strap capture
    always_comb begin
        next_gopt = gopt;
        next_gopt2 = gopt2;
        next_ctrl = ctrl;
        if (i_reset) begin
            // pins are sampled every reset cycle; the last one stays
            next_gopt = 8'h00;
            next_gopt[PNP_BIT] = i_port_a_term_ready_n;
            next_gopt[ROM_BIT] = i_port_a_serial_out;
            next_gopt[CLK48_BIT] = i_port_b_serial_out;
            next_gopt2 = 8'h00;
            next_gopt2[CFGADR_BIT] = i_port_a_req_to_send_n;
            next_ctrl = CTRL_RST;
        end else if (i_bus.wr) begin
            // software may override the captured values
            case (i_bus.addr)
                REG_GOPT: next_gopt = i_bus.wdata;
                REG_GOPT2: next_gopt2 = i_bus.wdata;
                REG_CTRL: next_ctrl = {4'h0, i_bus.wdata[3:0]};
                default: next_ctrl = ctrl;
            endcase
        end
        // address select follows the strap bit
        next_cfg_addr = next_gopt2[CFGADR_BIT] ? CFG_ADDR_ALT : DEF_ADDR;
        // modem outputs are active low
        next_mdm_n[0] = ~next_ctrl[CTRL_RTS_A];
        next_mdm_n[1] = ~next_ctrl[CTRL_DTR_A];
        next_mdm_n[2] = ~next_ctrl[CTRL_RTS_B];
        next_mdm_n[3] = ~next_ctrl[CTRL_DTR_B];
        // pull-down only while in reset, pins released after
        next_pull_dn = i_reset;
        next_pins_on = ~i_reset;
    end

    // configuration flops
    always_ff @(posedge i_clk) begin
        gopt <= next_gopt;
        gopt2 <= next_gopt2;
        ctrl <= next_ctrl;
        cfg_addr <= next_cfg_addr;
        mdm_n <= next_mdm_n;
        pull_dn <= next_pull_dn;
        pins_on <= next_pins_on;
    end

    // transmit buffers and shifters, one per port
    logic [7:0] fifo [2][FIFO_DEPTH];
    logic [7:0] next_fifo [2][FIFO_DEPTH];
    logic wptr [2], next_wptr [2];
    logic rptr [2], next_rptr [2];
    logic [1:0] cnt [2], next_cnt [2];
    ups_state_type tx_st [2], next_tx_st [2];
    logic [7:0] tx_sh [2], next_tx_sh [2];
    logic [2:0] tx_bit [2], next_tx_bit [2];
    logic [CW-1:0] tx_cnt [2], next_tx_cnt [2];
    logic tx_line [2], next_tx_line [2];

    // buffer fill and drain, shifter sequence
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        for (int p = 0; p < 2; p++) begin
            next_fifo[p] = fifo[p];
            next_wptr[p] = wptr[p];
            next_rptr[p] = rptr[p];
            next_tx_st[p] = tx_st[p];
            next_tx_sh[p] = tx_sh[p];
            next_tx_bit[p] = tx_bit[p];
            next_tx_line[p] = tx_line[p];
            next_tx_cnt[p] = bit_end(tx_cnt[p]) ? '0 : tx_cnt[p] + 1'b1;
            // a write to a full buffer is dropped; o_tx_ready shows it
            push = i_bus.wr && (i_bus.addr == (p == 0 ? REG_TXA : REG_TXB))
                && (cnt[p] != 2'(FIFO_DEPTH));
            pop = (tx_st[p] == ST_IDLE) && (cnt[p] != 2'h0);
            if (push) begin
                next_fifo[p][wptr[p]] = i_bus.wdata;
                next_wptr[p] = ~wptr[p];
            end
            case (tx_st[p])
                // idle: line high, start when a word waits
                ST_IDLE: begin
                    next_tx_line[p] = 1'b1;
                    next_tx_cnt[p] = '0;
                    if (pop) begin
                        next_tx_sh[p] = fifo[p][rptr[p]];
                        next_rptr[p] = ~rptr[p];
                        next_tx_st[p] = ST_START;
                        next_tx_line[p] = 1'b0;
                    end
                end
                // start bit done: first data bit, lsb first
                ST_START: begin
                    if (bit_end(tx_cnt[p])) begin
                        next_tx_st[p] = ST_DATA;
                        next_tx_line[p] = tx_sh[p][0];
                        next_tx_bit[p] = 3'h0;
                    end
                end
                ST_DATA: begin
                    if (bit_end(tx_cnt[p])) begin
                        if (tx_bit[p] == 3'h7) begin
                            next_tx_st[p] = ST_STOP;
                            next_tx_line[p] = 1'b1;
                        end else begin
                            next_tx_sh[p] = tx_sh[p] >> 1;
                            next_tx_line[p] = tx_sh[p][1];
                            next_tx_bit[p] = tx_bit[p] + 3'h1;
                        end
                    end
                end
                ST_STOP: begin
                    if (bit_end(tx_cnt[p])) begin
                        next_tx_st[p] = ST_IDLE;
                    end
                end
                default: next_tx_st[p] = ST_IDLE;
            endcase
            next_cnt[p] = cnt[p] + 2'(push) - 2'(pop);
            next_txr[p] = (next_cnt[p] != 2'(FIFO_DEPTH));
            if (i_reset) begin
                next_wptr[p] = 1'b0;
                next_rptr[p] = 1'b0;
                next_cnt[p] = 2'h0;
                next_tx_st[p] = ST_IDLE;
                next_tx_line[p] = 1'b1;
                next_tx_bit[p] = 3'h0;
                next_txr[p] = 1'b1;
            end
        end
    end

    // transmit flops
    always_ff @(posedge i_clk) begin
        fifo <= next_fifo;
        wptr <= next_wptr;
        rptr <= next_rptr;
        cnt <= next_cnt;
        tx_st <= next_tx_st;
        tx_sh <= next_tx_sh;
        tx_bit <= next_tx_bit;
        tx_cnt <= next_tx_cnt;
        tx_line <= next_tx_line;
        txr <= next_txr;
    end

    // port a receiver
    ups_state_type rx_st, next_rx_st;
    logic [7:0] rx_sh, next_rx_sh;
    logic [7:0] rx_data, next_rx_data;
    logic [2:0] rx_bit, next_rx_bit;
    logic [CW-1:0] rx_cnt, next_rx_cnt;
    logic rx_full, next_rx_full;

    // receive sequence; a new word beats a read clear
    always_comb begin
        next_rx_st = rx_st;
        next_rx_sh = rx_sh;
        next_rx_data = rx_data;
        next_rx_bit = rx_bit;
        next_rx_cnt = bit_end(rx_cnt) ? '0 : rx_cnt + 1'b1;
        next_rx_full = rx_full;
        if (i_bus.rd && i_bus.addr == REG_RX) begin
            next_rx_full = 1'b0;
        end
        case (rx_st)
            // wait for a low start level on the line
            ST_IDLE: begin
                next_rx_cnt = '0;
                if (!i_port_a_serial_in) begin
                    next_rx_st = ST_START;
                end
            end
            // recheck start mid-bit, then sample bit centres
            ST_START: begin
                if (rx_cnt == HALF) begin
                    next_rx_cnt = '0;
                    next_rx_bit = 3'h0;
                    next_rx_st = i_port_a_serial_in ? ST_IDLE : ST_DATA;
                end
            end
            ST_DATA: begin
                if (bit_end(rx_cnt)) begin
                    next_rx_sh = {i_port_a_serial_in, rx_sh[7:1]};
                    next_rx_bit = rx_bit + 3'h1;
                    if (rx_bit == 3'h7) begin
                        next_rx_st = ST_STOP;
                    end
                end
            end
            // a good stop bit delivers the word
            ST_STOP: begin
                if (bit_end(rx_cnt)) begin
                    next_rx_st = ST_IDLE;
                    if (i_port_a_serial_in) begin
                        next_rx_data = rx_sh;
                        next_rx_full = 1'b1;
                    end
                end
            end
            default: next_rx_st = ST_IDLE;
        endcase
        if (i_reset) begin
            next_rx_st = ST_IDLE;
            next_rx_full = 1'b0;
            next_rx_bit = 3'h0;
            next_rx_data = 8'h00;
        end
    end

    // receive flops
    always_ff @(posedge i_clk) begin
        rx_st <= next_rx_st;
        rx_sh <= next_rx_sh;
        rx_data <= next_rx_data;
        rx_bit <= next_rx_bit;
        rx_cnt <= next_rx_cnt;
        rx_full <= next_rx_full;
    end

    // read data, valid the cycle after the strobe only
    always_comb begin
        next_rdata = 8'h00;
        if (i_bus.rd && !i_reset) begin
            case (i_bus.addr)
                REG_GOPT: next_rdata = gopt;
                REG_GOPT2: next_rdata = gopt2;
                REG_CTRL: next_rdata = ctrl;
                REG_RX: next_rdata = rx_data;
                REG_STAT: next_rdata = {2'h0, txr, rx_full,
                    ~i_modem.set_ready_n,
                    ~i_modem.ring_n,
                    ~i_modem.carrier_n};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // read data flop
    always_ff @(posedge i_clk) begin
        rdata <= next_rdata;
    end

    // outputs, all from flops
    assign o_rdata = rdata;
    assign o_cfg_port_addr = cfg_addr;
    assign o_pnp_default_clear_strap = gopt[PNP_BIT];
    assign o_boot_rom_enable_strap = gopt[ROM_BIT];
    assign o_clk48_select_bit = gopt[CLK48_BIT];
    assign o_tx_ready = txr;
    assign o_port_a_req_to_send_n = '{mdm_n[0], pins_on, pull_dn};
    assign o_port_a_term_ready_n = '{mdm_n[1], pins_on, pull_dn};
    assign o_port_a_serial_out = '{tx_line[0], pins_on, pull_dn};
    assign o_port_b_serial_out = '{tx_line[1], pins_on, pull_dn};
    assign o_port_b_req_to_send_n = mdm_n[2];
    assign o_port_b_term_ready_n = mdm_n[3];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    chk_pull_before_release: assert property ($rose(pins_on) |-> $past(pull_dn))
        else $error("pins released without prior pull-down");
    chk_addr_strap_cap: assert property ($fell(i_reset)
        |-> gopt2[CFGADR_BIT] == $past(i_port_a_req_to_send_n))
        else $error("address strap not captured");
    chk_cfg_addr_sel: assert property (
        cfg_addr == (gopt2[CFGADR_BIT] ? CFG_ADDR_ALT : DEF_ADDR))
        else $error("configuration address wrong");
    chk_pnp_strap_cap: assert property ($fell(i_reset)
        |-> gopt[PNP_BIT] == $past(i_port_a_term_ready_n))
        else $error("pnp strap not captured");
    chk_rom_strap_cap: assert property ($fell(i_reset)
        |-> gopt[ROM_BIT] == $past(i_port_a_serial_out))
        else $error("rom strap not captured");
    chk_clk48_strap_cap: assert property ($fell(i_reset)
        |-> gopt[CLK48_BIT] == $past(i_port_b_serial_out))
        else $error("clock strap not captured");
    chk_rts_follows_ctrl: assert property (i_bus.wr && i_bus.addr == REG_CTRL
        |=> o_port_a_req_to_send_n.drive == !$past(i_bus.wdata[CTRL_RTS_A]))
        else $error("rts pin does not follow control");
    chk_tx_start_bit: assert property (i_bus.wr && i_bus.addr == REG_TXA
        && cnt[0] == 2'h0 && tx_st[0] == ST_IDLE
        |-> ##2 !o_port_a_serial_out.drive ##1 !o_port_a_serial_out.drive)
        else $error("start bit not sent");
    chk_pins_returned: assert property ($fell(i_reset)
        |=> pins_on && !pull_dn)
        else $error("pins not returned after reset");
endmodule : ups_strap_top

/* tb/tb_ups_strap_top.sv */
/*
 tb_ups_strap_top: register-port bench for strap capture, modem pins and serial ports.
 assumes ups_modem_model on the far side and board pull-ups set per strap pattern.
*/
`timescale 1ns/100ps
module tb_ups_strap_top;
    import ups_pkg::*;
    localparam int BAUD = 4; // short bit time keeps frames brief
    logic i_clk;
    logic i_reset;
    ups_bus_req_type i_bus;
    logic [7:0] o_rdata;
    ups_pin_type p_rts_a, p_dtr_a, p_sout_a, p_sout_b;
    logic rts_b_n, dtr_b_n, sin;
    ups_modem_in_type modem;
    logic [7:0] cfg_addr;
    logic pnp, rom, clk48;
    logic [1:0] tx_ready;
    logic [3:0] straps; // board pull-ups: rts a, dtr a, sout a, sout b
    logic w_rts_a, w_dtr_a, w_sout_a, w_sout_b;
    int miscompares;
    int n_compared;
    logic [7:0] words[4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    // wire level: driven value, else board pull-up beats the weak pull-down
    assign w_rts_a = p_rts_a.oe ? p_rts_a.drive : straps[3];
    assign w_dtr_a = p_dtr_a.oe ? p_dtr_a.drive : straps[2];
    assign w_sout_a = p_sout_a.oe ? p_sout_a.drive : straps[1];
    assign w_sout_b = p_sout_b.oe ? p_sout_b.drive : straps[0];
    ups_strap_top #(.BAUD(BAUD)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_bus(i_bus),
        .o_rdata(o_rdata), .i_port_a_req_to_send_n(w_rts_a),
        .i_port_a_term_ready_n(w_dtr_a), .i_port_a_serial_out(w_sout_a),
        .i_port_b_serial_out(w_sout_b), .o_port_a_req_to_send_n(p_rts_a),
        .o_port_a_term_ready_n(p_dtr_a), .o_port_a_serial_out(p_sout_a),
        .o_port_b_serial_out(p_sout_b), .o_port_b_req_to_send_n(rts_b_n),
        .o_port_b_term_ready_n(dtr_b_n), .i_port_a_serial_in(sin), .i_modem(modem),
        .o_cfg_port_addr(cfg_addr), .o_pnp_default_clear_strap(pnp),
        .o_boot_rom_enable_strap(rom), .o_clk48_select_bit(clk48), .o_tx_ready(tx_ready));
    ups_modem_model #(.BAUD(BAUD)) modem_u (.i_clk(i_clk), .i_reset(i_reset),
        .i_line_a(w_sout_a), .i_line_b(w_sout_b), .o_serial_in(sin), .o_modem(modem));
    // free-running clock, 4 ns
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // value compare, counts every call
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // write strobe stays up; another wr or idle follows
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
    endtask : wr
    task automatic idle(input int n);
        i_bus <= '0;
        repeat (n) @(posedge i_clk);
    endtask : idle
    // read data stand in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, exp, mask, input string what);
        i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        i_bus <= '0;
        @(posedge i_clk);
        chk(o_rdata & mask, exp, what);
    endtask : rd_chk
    task automatic wait_q(input bit p, input int n);
        for (int i = 0; i < 400; i++) begin
            if ((p ? modem_u.rx_q_b.size() : modem_u.rx_q_a.size()) >= n)
                return;
            @(posedge i_clk);
        end
        // a frame that never arrives counts against the run
        miscompares++;
        $display("[ERR] %0t receive queue wait timed out", $time);
    endtask : wait_q
    // reset with a strap pattern, then check capture and pin hand-back
    task automatic do_reset(input logic [3:0] s);
        straps <= s;
        i_reset <= 1'b1;
        i_bus <= '0;
        repeat (2) @(posedge i_clk);
        chk({p_rts_a.oe, p_dtr_a.oe, p_sout_a.oe, p_sout_b.oe, p_rts_a.pull_down,
            p_dtr_a.pull_down, p_sout_a.pull_down, p_sout_b.pull_down}, 8'h0F, "pins in reset");
        i_reset <= 1'b0;
        repeat (2) @(posedge i_clk);
        chk({p_rts_a.oe, p_dtr_a.oe, p_sout_a.oe, p_sout_b.oe, p_rts_a.pull_down,
            p_dtr_a.pull_down, p_sout_a.pull_down, p_sout_b.pull_down}, 8'hF0, "pins released");
        chk({4'h0, w_rts_a, w_dtr_a, rts_b_n, dtr_b_n}, 8'h0F, "modem pins idle");
        chk(cfg_addr, s[3] ? CFG_ADDR_ALT : CFG_ADDR_DEF, "config address");
        chk({5'h0, pnp, rom, clk48}, {5'h0, s[2], s[1], s[0]}, "strap outputs");
        rd_chk(REG_GOPT, {1'b0, s[0], 4'h0, s[1], s[2]}, 8'h43, "option reg");
        rd_chk(REG_GOPT2, {1'b0, s[3], 6'h00}, 8'h40, "option2 reg");
    endtask : do_reset
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // hang guard, well beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
    // main sequence
    initial begin
        miscompares = 0;
        n_compared = 0;
        do_reset(4'b0101);
        do_reset(4'b1010);
        $display("test straps done");
        // modem control pins, active low
        wr(REG_CTRL, 8'h0F);
        idle(2);
        chk({4'h0, w_rts_a, w_dtr_a, rts_b_n, dtr_b_n}, 8'h00, "control asserted");
        wr(REG_CTRL, 8'h05);
        idle(2);
        chk({4'h0, w_rts_a, w_dtr_a, rts_b_n, dtr_b_n}, 8'h05, "rts only");
        chk(cfg_addr, CFG_ADDR_ALT, "strap kept after release");
        rd_chk(REG_CTRL, 8'h05, 8'h0F, "control readback");
        wr(REG_CTRL, 8'h00);
        idle(1);
        $display("test control done");
        // modem status inputs, low is asserted
        modem_u.set_lines(3'b010);
        idle(4);
        rd_chk(REG_STAT, 8'h05, 8'h07, "carrier and set ready");
        modem_u.set_lines(3'b101);
        idle(4);
        rd_chk(REG_STAT, 8'h02, 8'h07, "ringing");
        modem_u.set_lines(3'b111);
        idle(4);
        $display("test status done");
        // odd accesses and software override of the straps
        rd_chk(8'h10, 8'h00, 8'hFF, "unmapped read");
        wr(REG_STAT, 8'hFF);
        wr(REG_GOPT, 8'h41);
        wr(REG_GOPT2, 8'h00);
        idle(2);
        rd_chk(REG_STAT, 8'h00, 8'h0F, "status ignores writes");
        chk(cfg_addr, CFG_ADDR_DEF, "default address");
        chk({5'h0, pnp, rom, clk48}, 8'h05, "overridden straps");
        $display("test registers done");
        // transmit: fill port a until refused, one word on port b
        for (int i = 0; i < 4; i++)
            wr(REG_TXA, words[i]);
        wr(REG_TXB, 8'h96);
        idle(2);
        chk({6'h00, tx_ready}, 8'h02, "a full, b free");
        wait_q(1'b0, 3);
        wait_q(1'b1, 1);
        for (int i = 0; i < 3; i++)
            chk(modem_u.rx_q_a[i], words[i], "port a word");
        chk(modem_u.rx_q_b[0], 8'h96, "port b word");
        idle(60);
        chk(8'(modem_u.rx_q_a.size()), 8'd3, "dropped word not sent");
        rd_chk(REG_STAT, 8'h30, 8'h30, "buffers drained");
        $display("test transmit done");
        // receive: good frame, bad stop, good frame again
        modem_u.send_byte(8'h3C, 1'b1);
        idle(4);
        rd_chk(REG_STAT, 8'h08, 8'h08, "receive full");
        rd_chk(REG_RX, 8'h3C, 8'hFF, "received word");
        rd_chk(REG_STAT, 8'h00, 8'h08, "read clears full");
        modem_u.send_byte(8'hC3, 1'b0);
        idle(4);
        rd_chk(REG_STAT, 8'h00, 8'h08, "bad stop dropped");
        modem_u.send_byte(8'h5A, 1'b1);
        idle(4);
        rd_chk(REG_RX, 8'h5A, 8'hFF, "word after bad frame");
        $display("test receive done");
        end_sim();
    end
endmodule : tb_ups_strap_top

/* tb/ups_modem_model.sv */
/*
 ups_modem_model: far-side modem for the serial ports of the strap block.
 assumes the lines are sampled on the rising edge of the block clock.
*/
`timescale 1ns/100ps
module ups_modem_model #(
    parameter int BAUD = 4
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_line_a,
    input wire logic i_line_b,
    output logic o_serial_in,
    output ups_pkg::ups_modem_in_type o_modem
);
    import ups_pkg::*;
    logic [7:0] rx_q_a[$]; // words seen on port a line
    logic [7:0] rx_q_b[$]; // words seen on port b line
    // idle line high, status lines inactive
    initial begin
        o_serial_in = 1'b1;
        o_modem = '1;
    end
    // status levels, low means asserted
    task automatic set_lines(input logic [2:0] lv);
        o_modem <= ups_modem_in_type'(lv);
    endtask : set_lines
    // one frame, lsb first, stop level chosen by caller
    task automatic send_byte(input logic [7:0] d, input logic stop);
        o_serial_in <= 1'b0;
        repeat (BAUD) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            o_serial_in <= d[i];
            repeat (BAUD) @(posedge i_clk);
        end
        o_serial_in <= stop;
        repeat (BAUD) @(posedge i_clk);
        o_serial_in <= 1'b1;
        repeat (BAUD) @(posedge i_clk);
    endtask : send_byte
    // level of the chosen line
    function automatic logic lvl(input bit p);
        return p ? i_line_b : i_line_a;
    endfunction : lvl
    // falling edge after a high level starts a frame; mid-bit sampling
    task automatic rx_loop(input bit p);
        logic prev;
        logic [7:0] d;
        prev = 1'b0;
        forever begin
            @(posedge i_clk);
            if (!i_reset && prev === 1'b1 && lvl(p) === 1'b0) begin
                repeat (BAUD / 2) @(posedge i_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BAUD) @(posedge i_clk);
                    d[i] = lvl(p);
                end
                repeat (BAUD) @(posedge i_clk);
                if (p)
                    rx_q_b.push_back(d);
                else
                    rx_q_a.push_back(d);
            end
            prev = i_reset ? 1'b0 : lvl(p);
        end
    endtask : rx_loop
    // both receivers run for the whole test
    initial begin
        fork
            rx_loop(1'b0);
            rx_loop(1'b1);
        join_none
    end
endmodule : ups_modem_model
